// file: logic/csif_status_flags.sv
`timescale 1ns/1ps
module csif_status_flags
  import csif_pkg::*;
#(
  parameter int PULSE_CYCLES = CSIF_PULSE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] short_det,
  input  wire logic       lcom_powered,
  input  wire logic       rcom_powered,
  input  wire logic       button_press,
  input  wire logic       headset_present,
  input  wire logic [1:0] agc_below,
  input  wire logic       irq_continuous,
  input  wire logic       rd_strobe,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data_q,
  output logic            rd_valid_q,
  output logic            irq_q
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic       rd_drv;
  logic       rd_latched;
  logic       rd_live;
  logic       rd_btn_clr;

  // Strobe qualified match, one per decoded address
  function automatic logic addr_hit(
    input logic       strobe,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return strobe && (addr == target);
  endfunction : addr_hit

  assign rd_drv     = addr_hit(rd_strobe, rd_addr, CSIF_ADDR_DRV_STAT);
  assign rd_latched = addr_hit(rd_strobe, rd_addr, CSIF_ADDR_LATCHED);
  assign rd_live    = addr_hit(rd_strobe, rd_addr, CSIF_ADDR_LIVE);
  assign rd_btn_clr = addr_hit(rd_strobe, rd_addr, CSIF_ADDR_BTN_CLR);

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  logic       hset_prev_q;
  logic       hset_edge;
  logic [7:0] set_vec;
  logic [7:0] flags_q;
  logic       new_event;
  logic       pending;

  // Both insertion and removal count as a headset event
  assign hset_edge = headset_present ^ hset_prev_q;

  // Level sets: a condition still true re-sets its flag after a read
  assign set_vec = {short_det,
                    button_press,
                    hset_edge,
                    agc_below};

  assign new_event = |(set_vec & ~flags_q);
  assign pending   = |flags_q;

  csif_sticky_bank #(
    .WIDTH   (8)
  ) csif_sticky_bank_inst (
    .clk     (clk),
    .reset   (reset),
    .set_in  (set_vec),
    .clr     (rd_latched),
    .flags_q (flags_q)
  );

  // ----------------------------------------
  // Live button bit (sticky)
  // ----------------------------------------
  logic       btn_rt_q;
  logic       btn_rt_d;

  // Only a read of the button-clear address drops it; press wins
  assign btn_rt_d = (btn_rt_q && !rd_btn_clr) || button_press;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      btn_rt_q    <= 1'h0;
      hset_prev_q <= 1'h0;
    end else begin
      btn_rt_q    <= btn_rt_d;
      hset_prev_q <= headset_present;
    end
  end

  // ----------------------------------------
  // Register images
  // ----------------------------------------
  logic [7:0] drv_img;
  logic [7:0] live_img;
  logic [7:0] rd_data_d;

  assign drv_img = {short_det,
                    lcom_powered,
                    rcom_powered,
                    CSIF_RSVD_VAL};

  assign live_img = {short_det,
                     btn_rt_q,
                     headset_present,
                     agc_below};

  assign rd_data_d = rd_drv     ? drv_img  :
                     rd_latched ? flags_q  :
                     rd_live    ? live_img :
                     CSIF_UNMAPPED;

  // Read data is taken before the same-edge clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data_q  <= CSIF_FLAG_RESET;
      rd_valid_q <= 1'h0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_strobe;
    end
  end

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  csif_int_pulser #(
    .TICK_CYCLES (PULSE_CYCLES)
  ) csif_int_pulser_inst (
    .clk         (clk),
    .reset       (reset),
    .continuous  (irq_continuous),
    .pending     (pending),
    .new_event   (new_event),
    .int_q       (irq_q)
  );

  // ----------------------------------------
  // Pulse width watch
  // ----------------------------------------
  // A full pulse is too long to unroll in a property, so its cycles are counted
  localparam int HIGH_W = $clog2(PULSE_CYCLES + 1);

  logic [HIGH_W-1:0] high_cnt_q;
  logic [HIGH_W-1:0] high_cnt_d;

  assign high_cnt_d = irq_q ? high_cnt_q + 1'h1 : '0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      high_cnt_q <= '0;
    end else begin
      high_cnt_q <= high_cnt_d;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_rcom_short: assert property (@(posedge clk) disable iff (reset)
    rd_drv |=> rd_data_q[4] == $past(short_det[0]))
    else $error("driver status bit 4 wrong");

  a_drv_shorts: assert property (@(posedge clk) disable iff (reset)
    rd_drv |=> rd_data_q[7:5] == $past(short_det[3:1]))
    else $error("driver status bits 7 to 5 wrong");

  a_lcom_power: assert property (@(posedge clk) disable iff (reset)
    rd_drv |=> rd_data_q[CSIF_BIT_LCOM_PWR] == $past(lcom_powered))
    else $error("left common power bit wrong");

  a_rcom_power: assert property (@(posedge clk) disable iff (reset)
    rd_drv |=> rd_data_q[CSIF_BIT_RCOM_PWR] == $past(rcom_powered))
    else $error("right common power bit wrong");

  a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    rd_drv |=> rd_data_q[1:0] == CSIF_RSVD_VAL)
    else $error("reserved bits not zero");

  a_sticky_sets: assert property (@(posedge clk) disable iff (reset)
    |short_det |=> (flags_q[7:4] & $past(short_det)) == $past(short_det))
    else $error("short event not latched");

  a_button_latch: assert property (@(posedge clk) disable iff (reset)
    button_press |=> flags_q[CSIF_BIT_BTN] && btn_rt_q)
    else $error("button press not latched");

  a_headset_edge: assert property (@(posedge clk) disable iff (reset)
    headset_present != hset_prev_q |=> flags_q[CSIF_BIT_HSET])
    else $error("headset change not latched");

  a_headset_track: assert property (@(posedge clk) disable iff (reset)
    1'h1 |=> hset_prev_q == $past(headset_present))
    else $error("headset history not tracking");

  a_agc_latch: assert property (@(posedge clk) disable iff (reset)
    |agc_below |=> (flags_q[1:0] & $past(agc_below)) == $past(agc_below))
    else $error("noise gate event not latched");

  a_live_map: assert property (@(posedge clk) disable iff (reset)
    rd_live |=> rd_data_q[7:4] == $past(short_det)
             && rd_data_q[CSIF_BIT_HSET] == $past(headset_present)
             && rd_data_q[1:0] == $past(agc_below))
    else $error("live flags mismatch");

  a_live_btn_read: assert property (@(posedge clk) disable iff (reset)
    rd_live |=> rd_data_q[CSIF_BIT_BTN] == $past(btn_rt_q))
    else $error("live button bit read wrong");

  a_live_button: assert property (@(posedge clk) disable iff (reset)
    btn_rt_q && !rd_btn_clr |=> btn_rt_q)
    else $error("live button bit cleared without register 14 read");

  a_button_clear: assert property (@(posedge clk) disable iff (reset)
    rd_btn_clr && !button_press |=> !btn_rt_q ##1 btn_rt_q == $past(button_press))
    else $error("live button bit not cleared by register 14 read");

  a_button_no_set: assert property (@(posedge clk) disable iff (reset)
    !btn_rt_q && !button_press |=> !btn_rt_q)
    else $error("live button bit set without a press");

  a_sticky_hold: assert property (@(posedge clk) disable iff (reset)
    !rd_latched |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("latched flag lost without read");

  a_no_spurious: assert property (@(posedge clk) disable iff (reset)
    1'h1 |=> (flags_q & ~$past(flags_q) & ~$past(set_vec)) == '0)
    else $error("latched flag set without its condition");

  a_sticky_clear: assert property (@(posedge clk) disable iff (reset)
    rd_latched && set_vec == '0 |=> flags_q == '0 && rd_data_q == $past(flags_q))
    else $error("latched read did not clear flags");

  a_latched_image: assert property (@(posedge clk) disable iff (reset)
    rd_latched |=> rd_data_q == $past(flags_q))
    else $error("latched read returned wrong flags");

  a_unmapped_read: assert property (@(posedge clk) disable iff (reset)
    rd_strobe && !rd_drv && !rd_latched && !rd_live |=> rd_data_q == CSIF_UNMAPPED)
    else $error("unmapped read not zero");

  a_idle_read: assert property (@(posedge clk) disable iff (reset)
    !rd_strobe |=> !rd_valid_q && rd_data_q == CSIF_UNMAPPED)
    else $error("read port not idle without strobe");

  a_irq_needs_flag: assert property (@(posedge clk) disable iff (reset)
    $past(irq_continuous) && irq_q |-> $past(pending))
    else $error("continuous interrupt high with no flag set");

  a_single_width: assert property (@(posedge clk) disable iff (reset)
    $fell(irq_q) && !$past(irq_continuous) |-> high_cnt_q == HIGH_W'(PULSE_CYCLES))
    else $error("single interrupt pulse width wrong");

  a_read_valid: assert property (@(posedge clk) disable iff (reset)
    rd_strobe |=> rd_valid_q ##1 !rd_valid_q || $past(rd_strobe))
    else $error("read valid not one cycle");

  c_latched_read: cover property (@(posedge clk) disable iff (reset)
    rd_latched && pending ##1 !pending);

  c_button_clear: cover property (@(posedge clk) disable iff (reset)
    btn_rt_q && rd_btn_clr ##1 !btn_rt_q);

  c_headset_out: cover property (@(posedge clk) disable iff (reset)
    hset_prev_q && !headset_present);

  c_irq_pulse: cover property (@(posedge clk) disable iff (reset)
    irq_continuous && !irq_q ##1 irq_q);

  c_single_pulse: cover property (@(posedge clk) disable iff (reset)
    !irq_continuous && $fell(irq_q));

endmodule : csif_status_flags

// file: common/csif_pkg.sv
// Summary of operation
// - Driver status bit 4 reads 1 while the right common-mode driver is shorted, else 0.
// - Driver status bit 3 reads 1 only while the left common-mode driver is fully powered.
// - Driver status bit 2 reads 1 only while the right common-mode driver is fully powered.
// - Driver status bits 1 and 0 are reserved, read as 00, and the host never writes them.
// - Latched bits 7 to 4 catch shorts on the left, right, left-common and right-common drivers.
// - Latched flag bit 3 is set by a headset button press and stays 0 without one.
// - Latched flag bit 2 is set by a headset insertion or a headset removal.
// - Latched flag bits 1 and 0 are set when left or right record power falls below its gate.
// - Live flags show current conditions in the latched layout, except sticky button bit 3, eight read-only bits reset to 0.
// - Live flag bits 7 to 4 show the present short state of the four headphone drivers.
// - Live flag bit 2 reads 1 while a headset is present and 0 while none is.
// - Live button bit 3 is sticky and is cleared only by a host read of page 0 register 14.
// - Live flag bits 1 and 0 read 1 while left or right record power is below its gate.
// - Driver status bits 7 to 5 report shorts on the left, right and left-common drivers.
// - In continuous mode the interrupt pulses while any latched flag is set, so it stops only once a latched read leaves none set.
package csif_pkg;

  localparam logic [7:0] CSIF_ADDR_DRV_STAT = 8'h5F;
  localparam logic [7:0] CSIF_ADDR_LATCHED  = 8'h60;
  localparam logic [7:0] CSIF_ADDR_LIVE     = 8'h61;
  localparam logic [7:0] CSIF_ADDR_BTN_CLR  = 8'h0E;

  localparam int CSIF_BIT_LCOM_PWR = 3;
  localparam int CSIF_BIT_RCOM_PWR = 2;
  localparam int CSIF_BIT_BTN      = 3;
  localparam int CSIF_BIT_HSET     = 2;

  localparam logic [1:0] CSIF_RSVD_VAL   = 2'h0;
  localparam logic [7:0] CSIF_FLAG_RESET = 8'h00;
  localparam logic [7:0] CSIF_UNMAPPED   = 8'h00;

  localparam int CSIF_CLK_MHZ       = 20;
  localparam int CSIF_PULSE_TIME_US = 2000;
  localparam int CSIF_PULSE_CYCLES  = CSIF_PULSE_TIME_US * CSIF_CLK_MHZ;

endpackage : csif_pkg

// file: logic/csif_sticky_bank.sv
`timescale 1ns/1ps
module csif_sticky_bank
  import csif_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic             clr,
  output logic      [WIDTH-1:0] flags_q
);

  logic [WIDTH-1:0] flags_d;

  generate
    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
      $error("csif_sticky_bank: WIDTH must be 1 to 8");
    end
  endgenerate

  // Set wins over clear so an event in the read cycle survives
  assign flags_d = (clr ? '0 : flags_q) | set_in;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_q <= CSIF_FLAG_RESET[WIDTH-1:0];
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule : csif_sticky_bank

// file: logic/csif_int_pulser.sv
`timescale 1ns/1ps
module csif_int_pulser
  import csif_pkg::*;
#(
  parameter int TICK_CYCLES = CSIF_PULSE_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic continuous,
  input  wire logic pending,
  input  wire logic new_event,
  output logic      int_q
);

  localparam int DIV_W = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic             tick;
  logic             arm_q;
  logic             arm_d;
  logic             int_d;

  generate
    if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("csif_int_pulser: TICK_CYCLES must be at least 2");
    end
  endgenerate

  // ----------------------------------------
  // Pulse-width divider
  // ----------------------------------------
  assign tick  = (div_q == DIV_LAST);
  assign div_d = tick ? '0 : div_q + 1'h1;

  // ----------------------------------------
  // Output shaping
  // ----------------------------------------
  // Single mode may wait up to one period before the pulse starts
  assign arm_d = (arm_q && !(tick && !int_q)) || new_event;
  assign int_d = continuous ? (pending && (tick ? !int_q : int_q)) :
                 (tick ? (!int_q && arm_q) : int_q);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_q <= '0;
      arm_q <= 1'h0;
      int_q <= 1'h0;
    end else begin
      div_q <= div_d;
      arm_q <= arm_d;
      int_q <= int_d;
    end
  end

  a_cont_toggle: assert property (@(posedge clk) disable iff (reset)
    continuous && pending && tick |=> int_q != $past(int_q))
    else $error("continuous interrupt did not toggle on tick");

  a_cont_stop: assert property (@(posedge clk) disable iff (reset)
    continuous && !pending |=> !int_q)
    else $error("interrupt kept pulsing after acknowledge");

endmodule : csif_int_pulser

// file: verification/csif_host_model.sv
`timescale 1ns/1ps
module csif_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data_q,
  input  wire logic       rd_valid_q,
  output logic            rd_strobe,
  output logic      [7:0] rd_addr
);

  initial begin
    rd_strobe = 1'b0;
    rd_addr   = 8'h00;
  end

  // ----------------------------------------------------------------
  // Single-byte read, launched and sampled on falling edges
  // ----------------------------------------------------------------
  // No write task on purpose: the reserved bits are never written
  // Reads of the latched flags or the clear address acknowledge events
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    @(negedge clk);
    rd_strobe = 1'b1;
    rd_addr   = addr;
    @(negedge clk);
    rd_strobe = 1'b0;
    // Released address must not keep the last value
    rd_addr   = ~addr;
    data      = rd_data_q;
    valid     = rd_valid_q;
  endtask : rd

endmodule : csif_host_model

// file: verification/csif_status_flags_test.sv
`timescale 1ns/1ps
module csif_status_flags_test;
  import csif_pkg::*;

  localparam int PULSE = 4;

  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [3:0] short_det = 4'h0;
  logic       lcom_powered = 1'b0;
  logic       rcom_powered = 1'b0;
  logic       button_press = 1'b0;
  logic       headset_present = 1'b0;
  logic [1:0] agc_below = 2'h0;
  logic       irq_continuous = 1'b0;
  logic       rd_strobe;
  logic [7:0] rd_addr;
  logic [7:0] rd_data_q;
  logic       rd_valid_q;
  logic       irq_q;
  int         error_cnt = 0;
  int         comparisons = 0;

  always #25 clk = ~clk;

  csif_status_flags #(.PULSE_CYCLES(PULSE)) csif_status_flags_inst (
    .clk(clk), .reset(reset), .short_det(short_det), .lcom_powered(lcom_powered),
    .rcom_powered(rcom_powered), .button_press(button_press),
    .headset_present(headset_present), .agc_below(agc_below),
    .irq_continuous(irq_continuous), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .irq_q(irq_q));

  csif_host_model csif_host_model_inst (
    .clk(clk), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .rd_strobe(rd_strobe), .rd_addr(rd_addr));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    csif_host_model_inst.rd(addr, d, v);
    chk(8'h01, {7'h00, v});
    chk(exp, d);
  endtask : rdchk

  // Bounded wait for a level on the interrupt line
  task automatic wait_irq(input logic lvl, input int bound);
    int n;
    n = 0;
    while (irq_q !== lvl && n < bound) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, lvl}, {7'h00, irq_q});
    if (irq_q !== lvl) print_verdict();
  endtask : wait_irq

  task automatic pulse_inputs(input logic [3:0] sd, input logic btn, input logic [1:0] agc);
    @(negedge clk);
    short_det    = sd;
    button_press = btn;
    agc_below    = agc;
    @(negedge clk);
    short_det    = 4'h0;
    button_press = 1'b0;
    agc_below    = 2'h0;
  endtask : pulse_inputs

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_reset_values();
    rdchk(CSIF_ADDR_DRV_STAT, 8'h00);
    rdchk(CSIF_ADDR_LATCHED, 8'h00);
    rdchk(CSIF_ADDR_LIVE, 8'h00);
  endtask : sc_reset_values

  task automatic sc_driver_status();
    short_det    = 4'h1;
    lcom_powered = 1'b1;
    rcom_powered = 1'b0;
    rdchk(CSIF_ADDR_DRV_STAT, 8'h18);
    short_det    = 4'hE;
    lcom_powered = 1'b0;
    rcom_powered = 1'b1;
    rdchk(CSIF_ADDR_DRV_STAT, 8'hE4);
    short_det    = 4'h0;
    rcom_powered = 1'b0;
    rdchk(CSIF_ADDR_LATCHED, 8'hF0);
  endtask : sc_driver_status

  task automatic sc_sticky_hold();
    pulse_inputs(4'h5, 1'b0, 2'h2);
    rdchk(CSIF_ADDR_LATCHED, 8'h52);
    rdchk(CSIF_ADDR_LATCHED, 8'h00);
    pulse_inputs(4'hA, 1'b0, 2'h1);
    rdchk(CSIF_ADDR_LATCHED, 8'hA1);
  endtask : sc_sticky_hold

  task automatic sc_button_headset();
    headset_present = 1'b1;
    pulse_inputs(4'h0, 1'b1, 2'h0);
    rdchk(CSIF_ADDR_LIVE, 8'h0C);
    rdchk(CSIF_ADDR_LATCHED, 8'h0C);
    rdchk(CSIF_ADDR_LIVE, 8'h0C);
    rdchk(CSIF_ADDR_BTN_CLR, 8'h00);
    rdchk(CSIF_ADDR_LIVE, 8'h04);
    headset_present = 1'b0;
    rdchk(CSIF_ADDR_LATCHED, 8'h04);
    rdchk(CSIF_ADDR_LATCHED, 8'h00);
  endtask : sc_button_headset

  task automatic sc_live_flags();
    short_det = 4'h9;
    agc_below = 2'h1;
    rdchk(CSIF_ADDR_LIVE, 8'h91);
    short_det = 4'h6;
    agc_below = 2'h2;
    rdchk(CSIF_ADDR_LIVE, 8'h62);
    short_det = 4'h0;
    agc_below = 2'h0;
    rdchk(8'h33, CSIF_UNMAPPED);
    rdchk(CSIF_ADDR_LATCHED, 8'hF3);
  endtask : sc_live_flags

  task automatic sc_irq_modes();
    irq_continuous = 1'b1;
    pulse_inputs(4'h1, 1'b0, 2'h0);
    wait_irq(1'b1, 4 * PULSE);
    @(negedge clk);
    wait_irq(1'b0, PULSE + 2);
    wait_irq(1'b1, PULSE + 2);
    rdchk(CSIF_ADDR_LATCHED, 8'h10);
    @(negedge clk);
    repeat (3 * PULSE) begin
      @(negedge clk);
      chk(8'h00, {7'h00, irq_q});
    end
    irq_continuous = 1'b0;
    pulse_inputs(4'h0, 1'b0, 2'h1);
    wait_irq(1'b1, 4 * PULSE);
    @(negedge clk);
    wait_irq(1'b0, PULSE + 2);
    repeat (3 * PULSE) begin
      @(negedge clk);
      chk(8'h00, {7'h00, irq_q});
    end
    rdchk(CSIF_ADDR_LATCHED, 8'h01);
  endtask : sc_irq_modes

  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    sc_reset_values();
    sc_driver_status();
    sc_sticky_hold();
    sc_button_headset();
    sc_live_flags();
    sc_irq_modes();
    print_verdict();
  end

endmodule : csif_status_flags_test
